// [rtl/lps_pkg.sv]
// ============================================================
// Shared constants and carriers
package lps_pkg;

  // Geometry of the link
  localparam int NUM_LANES = 5;
  localparam int UI_PER_PERIOD = 7;
  localparam int FIFO_DEPTH = 16;

  // Register map
  localparam logic [7:0] REG_SAMPLE_DELAY = 8'h19;
  localparam logic [7:0] REG_STATUS = 8'h1a;
  localparam int DELAY_FIELD_LSB = 0;
  localparam int DELAY_FIELD_W = 3;
  localparam logic [7:0] SAMPLE_DELAY_RESET = 8'h00;
  localparam int STAT_LOCK_BIT = 7;
  localparam int STAT_OE_BIT = 6;

  // Sampling shift steps in picoseconds
  localparam int LATER_STEP_PS = 400;
  localparam int EARLIER_STEP_PS = 200;

  // Clock and timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int WORD_PERIOD_PS = UI_PER_PERIOD * CLK_PERIOD_PS;
  localparam int CCD_PERIOD_MILLI = 1786;
  localparam int CCD_OFFSET_PS = 4190;
  localparam int CCD_PS = (CCD_PERIOD_MILLI * WORD_PERIOD_PS) / 1000 + CCD_OFFSET_PS
                          - 2 * CLK_PERIOD_PS;
  localparam int CCD_CYC = (CCD_PS / CLK_PERIOD_PS < 1) ? 1 : CCD_PS / CLK_PERIOD_PS;
  localparam int LOCK_TIME_MS = 10;
  localparam int LOCK_CYC = (LOCK_TIME_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int PDD_NS = 100;
  localparam int PDD_CYC = (PDD_NS * 1000) / CLK_PERIOD_PS;

  // Forwarded clock lane shape over the seven slots
  localparam logic [6:0] CLK_PATTERN = 7'h63;

  // One parallel word: seven input bits per lane
  typedef struct packed {
    logic [NUM_LANES-1:0][6:0] bits;
  } lps_word_s;

  // Configuration access from the serial port
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lps_cfg_s;

endpackage : lps_pkg

// [rtl/lps_fifo.sv]
`timescale 1ns/1ns
// ============================================================
// Word FIFO with valid/ready on both sides
module lps_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Occupancy
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  // Handshake terms
  assign in_ready = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end

endmodule : lps_fifo

// [rtl/lps_serializer.sv]
`timescale 1ns/1ns
// ============================================================
// 7:1 serializer core
module lps_serializer #(
  parameter int LOCK_CYCLES = lps_pkg::LOCK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Device enable pin
  input wire logic power_down_n,
  // Parallel pixel side
  input wire logic pixel_valid,
  input wire lps_pkg::lps_word_s parallel_pixel_inputs,
  output logic pixel_ready,
  // Configuration port
  input wire lps_pkg::lps_cfg_s cfg,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  // Sampling delay control to the input delay line
  output logic [2:0] sample_delay_sel,
  output logic signed [11:0] sample_shift_ps,
  // Serial lanes
  output logic [lps_pkg::NUM_LANES-1:0] serial_data,
  output logic serial_clk,
  output logic serial_oe,
  output logic pll_locked
);
  import lps_pkg::*;

  localparam int PDD_BOUND = PDD_CYC;
  localparam int FW = $bits(lps_word_s);

  // Bit sent in each slot
  function automatic logic [2:0] serial_bit_position(input logic [2:0] slot);
    unique case (slot)
      3'h0: serial_bit_position = 3'h1;
      3'h1: serial_bit_position = 3'h0;
      3'h2: serial_bit_position = 3'h6;
      3'h3: serial_bit_position = 3'h5;
      3'h4: serial_bit_position = 3'h4;
      3'h5: serial_bit_position = 3'h3;
      default: serial_bit_position = 3'h2;
    endcase
  endfunction : serial_bit_position

  // Sampling shift in ps, positive is later
  function automatic logic signed [11:0] shift_of(input logic [2:0] code);
    logic signed [11:0] step;
    step = 12'(LATER_STEP_PS);
    if (code[2]) begin
      shift_of = -(12'(EARLIER_STEP_PS) * (12'(code[1:0]) + 12'sh001));
    end else begin
      shift_of = step * 12'(code[1:0]);
    end
  endfunction : shift_of

  typedef enum logic [1:0] {ST_OFF, ST_LOCKING, ST_RUN} lps_state_e;

  lps_state_e state;
  logic [7:0] delay_reg;
  logic [$clog2(LOCK_CYCLES+1)-1:0] lock_cnt;
  logic cap_valid;
  lps_word_s cap_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic pop;
  logic [2:0] slot;
  lps_word_s cur_word;
  logic [2:0] pos;

  // ============================================================
  // Configuration registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      delay_reg <= SAMPLE_DELAY_RESET;
    end else if (cfg.wr_en && cfg.addr == REG_SAMPLE_DELAY) begin
      delay_reg <= cfg.wdata;
    end
  end

  // Delay line control
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sample_delay_sel <= '0;
      sample_shift_ps <= '0;
    end else begin
      sample_delay_sel <= delay_reg[DELAY_FIELD_LSB +: DELAY_FIELD_W];
      sample_shift_ps <= shift_of(delay_reg[DELAY_FIELD_LSB +: DELAY_FIELD_W]);
    end
  end

  // Register reads, unmapped reads return zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata <= '0;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg.rd_en;
      if (cfg.rd_en && cfg.addr == REG_SAMPLE_DELAY) begin
        cfg_rdata <= delay_reg;
      end else if (cfg.rd_en && cfg.addr == REG_STATUS) begin
        cfg_rdata <= {pll_locked, serial_oe, 1'b0, 5'(fifo_level)};
      end else begin
        cfg_rdata <= '0;
      end
    end
  end

  // ============================================================
  // Power and lock sequencing
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= ST_OFF;
      lock_cnt <= '0;
    end else if (!power_down_n) begin
      state <= ST_OFF;
      lock_cnt <= '0;
    end else begin
      unique case (state)
        ST_OFF: begin
          state <= ST_LOCKING;
        end
        ST_LOCKING: begin
          if (lock_cnt == ($bits(lock_cnt))'(LOCK_CYCLES - 1)) begin
            state <= ST_RUN;
          end
          lock_cnt <= lock_cnt + 1'b1;
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // Output enable and lock indication
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      serial_oe <= 1'b0;
      pll_locked <= 1'b0;
    end else begin
      serial_oe <= power_down_n && state == ST_RUN;
      pll_locked <= power_down_n && state == ST_RUN;
    end
  end

  // ============================================================
  // Input capture, margin covers the capture stage in flight
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pixel_ready <= 1'b0;
      cap_valid <= 1'b0;
      cap_word <= '0;
    end else begin
      pixel_ready <= power_down_n && state == ST_RUN
                     && fifo_level < ($bits(fifo_level))'(FIFO_DEPTH - 2);
      if (!power_down_n) begin
        cap_valid <= 1'b0;
      end else if (pixel_valid && pixel_ready) begin
        cap_valid <= 1'b1;
        cap_word <= parallel_pixel_inputs;
      end else if (fifo_in_ready) begin
        cap_valid <= 1'b0;
      end
    end
  end

  lps_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .flush(!power_down_n),
    .in_valid(cap_valid),
    .in_ready(fifo_in_ready),
    .in_data(cap_word),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // One word, if the FIFO holds any, leaves it at each period boundary
  assign pop = state == ST_RUN && slot == 3'h6 && power_down_n;
  assign pos = serial_bit_position(slot);

  // ============================================================
  // Slot counter and word holding
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slot <= '0;
      cur_word <= '0;
    end else if (state != ST_RUN || !power_down_n) begin
      slot <= '0;
      cur_word <= '0;
    end else begin
      slot <= (slot == 3'(UI_PER_PERIOD - 1)) ? 3'h0 : slot + 3'h1;
      if (slot == 3'h6) begin
        cur_word <= fifo_out_valid ? lps_word_s'(fifo_out_data) : '0;
      end
    end
  end

  // Serial bit and forwarded clock per unit interval
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      serial_data <= '0;
      serial_clk <= 1'b0;
    end else if (state != ST_RUN || !power_down_n) begin
      serial_data <= '0;
      serial_clk <= 1'b0;
    end else begin
      for (int l = 0; l < NUM_LANES; l++) begin
        serial_data[l] <= cur_word.bits[l][pos];
      end
      serial_clk <= CLK_PATTERN[slot];
    end
  end

  // ============================================================
  // Checks
  AST_SLOT_WRAP: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_RUN && power_down_n && slot == 3'h6) |=> slot == 3'h0)
    else $error("slot did not wrap after seventh interval");

  AST_BIT_ORDER: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_RUN && power_down_n && slot == 3'h0) ##1 (state == ST_RUN && power_down_n)
    |-> (serial_data[0] == $past(cur_word.bits[0][1])) ##5
        (state != ST_RUN || serial_data[0] == $past(cur_word.bits[0][3])))
    else $error("serial bit order wrong");

  AST_DELAY_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cfg.wr_en && cfg.addr == REG_SAMPLE_DELAY) |=> ##1 sample_delay_sel == $past(cfg.wdata[2:0], 2))
    else $error("sampling delay field not applied");

  AST_LATER: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!sample_delay_sel[2] && $stable(sample_delay_sel) && $past(delay_reg[2:0]) == sample_delay_sel)
    |-> sample_shift_ps == 12'sd400 * $signed({9'h000, sample_delay_sel}))
    else $error("later sampling shift wrong");

  AST_EARLIER: assert property (@(posedge clk_sys) disable iff (!rstn)
    (sample_delay_sel[2] && $stable(sample_delay_sel) && $past(delay_reg[2:0]) == sample_delay_sel)
    |-> sample_shift_ps == -12'sd200 * ($signed({10'h000, sample_delay_sel[1:0]}) + 12'sd1))
    else $error("earlier sampling shift wrong");

  AST_CLK_LANE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_RUN && power_down_n && slot == 3'h0) ##1 (state == ST_RUN && power_down_n)
    |-> serial_clk ##2 !serial_clk)
    else $error("forwarded clock not high in first interval");

  AST_LOCK_TIME: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_LOCKING) |-> lock_cnt < ($bits(lock_cnt))'(LOCK_CYCLES))
    else $error("lock wait exceeded lock time");

  AST_PD_DELAY: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(power_down_n) |-> ##[1:PDD_BOUND] (!serial_oe && !pll_locked))
    else $error("outputs not disabled after power down");

  AST_PD_LEVEL: assert property (@(posedge clk_sys) disable iff (!rstn)
    !power_down_n ##1 !power_down_n |-> !serial_oe && state == ST_OFF && serial_data == '0)
    else $error("device active while power down low");

  AST_NO_DROP: assert property (@(posedge clk_sys) disable iff (!rstn)
    (power_down_n && pixel_valid && pixel_ready) ##1 power_down_n
    |-> cap_valid && cap_word == $past(parallel_pixel_inputs))
    else $error("accepted word not captured");

endmodule : lps_serializer

// [verification/lps_rx_model.sv]
`timescale 1ns/1ns
// ============================================================
// Panel-side receiver that frames words on the clock lane shape
module lps_rx_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Serial lanes
  input wire logic [lps_pkg::NUM_LANES-1:0] serial_data,
  input wire logic serial_clk,
  input wire logic serial_oe,
  // Recovered words
  output lps_pkg::lps_word_s rx_word,
  output logic rx_stb
);
  import lps_pkg::*;
  logic [6:0] clk_hist;
  logic [6:0] dat_hist [NUM_LANES];
  // One bit per slot; a full 1100011 clock shape closes a word sent 1,0,6,5,4,3,2
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clk_hist <= '0;
      rx_stb <= 1'b0;
      rx_word <= '0;
      for (int l = 0; l < NUM_LANES; l++) dat_hist[l] <= '0;
    end else begin
      rx_stb <= 1'b0;
      if (!serial_oe) begin
        clk_hist <= '0;  // Lanes off: drop any partial frame
      end else begin
        clk_hist <= {clk_hist[5:0], serial_clk};
        for (int l = 0; l < NUM_LANES; l++) begin
          dat_hist[l] <= {dat_hist[l][5:0], serial_data[l]};
          rx_word.bits[l] <= {dat_hist[l][3:0], serial_data[l], dat_hist[l][5:4]};
        end
        if ({clk_hist[5:0], serial_clk} == 7'h63) rx_stb <= 1'b1;
      end
    end
  end
endmodule : lps_rx_model

// [verification/testbench.sv]
`timescale 1ns/1ns
// ============================================================
// Self-checking bench for the serializer core
module testbench;
  import lps_pkg::*;
  localparam int LOCK_SIM = 20;
  logic clk_sys, rstn, power_down_n, pixel_valid, pixel_ready, cfg_rvalid, rx_stb;
  logic serial_clk, serial_oe, pll_locked;
  logic [NUM_LANES-1:0] serial_data;
  lps_word_s parallel_pixel_inputs, rx_word;
  lps_cfg_s cfg;
  logic [7:0] cfg_rdata, rd;
  logic [2:0] sample_delay_sel;
  logic signed [11:0] sample_shift_ps;
  int n_errors = 0, checked = 0, cycles = 0;
  lps_word_s rxq[$];

  lps_serializer #(.LOCK_CYCLES(LOCK_SIM)) lps_serializer_i (.clk_sys(clk_sys), .rstn(rstn),
    .power_down_n(power_down_n), .pixel_valid(pixel_valid),
    .parallel_pixel_inputs(parallel_pixel_inputs), .pixel_ready(pixel_ready), .cfg(cfg),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .sample_delay_sel(sample_delay_sel),
    .sample_shift_ps(sample_shift_ps), .serial_data(serial_data), .serial_clk(serial_clk),
    .serial_oe(serial_oe), .pll_locked(pll_locked));
  lps_rx_model lps_rx_model_i (.clk_sys(clk_sys), .rstn(rstn), .serial_data(serial_data),
    .serial_clk(serial_clk), .serial_oe(serial_oe), .rx_word(rx_word), .rx_stb(rx_stb));

  // Clock and timeout
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (rx_stb && rx_word !== '0) rxq.push_back(rx_word);
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(string what, logic [34:0] exp, logic [34:0] got);
    checked++;
    if (exp !== got) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cfg_wr(logic [7:0] a, logic [7:0] d);
    cfg = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys);
    cfg = '0;
    @(negedge clk_sys);  // Idle cycle so the next access never reassigns cfg in this step
  endtask : cfg_wr

  task automatic cfg_rd(logic [7:0] a, output logic [7:0] d);
    cfg = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys);
    cfg = '0;
    chk("rvalid", 35'h1, 35'(cfg_rvalid));
    d = cfg_rdata;
    @(negedge clk_sys);  // Idle cycle before the next access
  endtask : cfg_rd

  // Wait for lock under a bound
  task automatic wait_lock();
    int n = 0;
    while (pll_locked !== 1'b1 && n < LOCK_SIM + 6) begin
      @(negedge clk_sys);
      n++;
    end
    chk("lock", 35'h1, 35'(pll_locked));
    chk("oe", 35'h1, 35'(serial_oe));
  endtask : wait_lock

  function automatic lps_word_s mkw(int i);
    lps_word_s w;
    for (int l = 0; l < NUM_LANES; l++) w.bits[l] = 7'(i * 5 + l * 3 + 1);
    return w;
  endfunction : mkw

  // Every sampling-delay code, read back and decoded
  task automatic t_delay_codes();
    logic signed [11:0] es;
    cfg_rd(REG_SAMPLE_DELAY, rd);
    chk("reg19 reset", 35'(SAMPLE_DELAY_RESET), 35'(rd));
    for (int c = 0; c < 8; c++) begin
      es = (c == 0) ? 12'sh000 : (c < 4) ? 12'(c * LATER_STEP_PS) : 12'(-(c - 3) * EARLIER_STEP_PS);
      cfg_wr(REG_SAMPLE_DELAY, {5'h1a, 3'(c)});
      repeat (2) @(negedge clk_sys);
      chk("delay sel", 35'(c), 35'(sample_delay_sel));
      chk("shift ps", 35'(es), 35'(sample_shift_ps));
      cfg_rd(REG_SAMPLE_DELAY, rd);
      chk("reg19", 35'({5'h1a, 3'(c)}), 35'(rd));
    end
    cfg_wr(8'h77, 8'h5a);
    cfg_rd(8'h77, rd);
    chk("unmapped", 35'h0, 35'(rd));
    cfg_wr(REG_SAMPLE_DELAY, 8'h03);
  endtask : t_delay_codes

  // Burst n words, holding through refusals, then drain; every word once, in order
  task automatic t_stream(int n);
    int i = 0, g = 0;
    bit rdy, refused = 0;
    rxq.delete();
    pixel_valid = 1'b1;
    parallel_pixel_inputs = mkw(0);
    while (i < n && g < 2000) begin
      rdy = pixel_ready;
      refused |= !rdy;
      @(negedge clk_sys);
      g++;
      if (rdy) begin
        i++;
        if (i < n) parallel_pixel_inputs = mkw(i);
      end
    end
    pixel_valid = 1'b0;
    parallel_pixel_inputs = '1;
    g = 0;
    while (rxq.size() < n && g < 20 * 7 + 40) begin
      @(negedge clk_sys);
      g++;
    end
    chk("word count", 35'(n), 35'(rxq.size()));
    for (int k = 0; k < rxq.size() && k < n; k++) chk("word", mkw(k), rxq[k]);
    if (n > FIFO_DEPTH) chk("refused", 35'h1, 35'(refused));
    repeat (14) @(negedge clk_sys);
    cfg_rd(REG_STATUS, rd);
    chk("status", 35'h0c0, 35'(rd));
  endtask : t_stream

  // Power down mid-stream, then recover
  task automatic t_power_down();
    int n = 0;
    pixel_valid = 1'b1;
    parallel_pixel_inputs = mkw(40);
    repeat (9) @(negedge clk_sys);
    power_down_n = 1'b0;
    pixel_valid = 1'b0;
    while (serial_oe !== 1'b0 && n < 12) begin
      @(negedge clk_sys);
      n++;
    end
    chk("pd delay ok", 35'h1, 35'(n <= PDD_CYC));
    chk("pd locked", 35'h0, 35'(pll_locked));
    chk("pd data", 35'h0, 35'(serial_data));
    chk("pd ready", 35'h0, 35'(pixel_ready));
    cfg_rd(REG_SAMPLE_DELAY, rd);
    chk("reg19 kept", 35'h3, 35'(rd));
    power_down_n = 1'b1;
    wait_lock();
    t_stream(3);
  endtask : t_power_down

  // Main sequence
  initial begin
    rstn = 1'b0;
    power_down_n = 1'b1;
    pixel_valid = 1'b0;
    parallel_pixel_inputs = '0;
    cfg = '0;
    repeat (20) @(negedge clk_sys);
    chk("reset oe", 35'h0, 35'(serial_oe));
    rstn = 1'b1;
    t_delay_codes();
    wait_lock();
    t_stream(24);
    t_power_down();
    close_out();
  end
endmodule : testbench
